// ---- eew_host.sv ----
// Two-wire bus controller model driving the serial pins
`timescale 1ns/100ps
module eew_host (
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  // ----
  // Bit period 2800 ns keeps the clock under 400 kHz
  // ----
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic start();
    sda_low = 1'b0;
    #800 scl = 1'b1;
    #800 sda_low = 1'b1;
    #800 scl = 1'b0;
  endtask
  task automatic stop();
    sda_low = 1'b1;
    #800 scl = 1'b1;
    #800 sda_low = 1'b0;
    #1200;
  endtask
  // Clock pulse of 40 ns inside a low phase, too short to count
  task automatic glitch();
    #210 scl = 1'b1;
    #40 scl = 1'b0;
    #150;
  endtask
  // Data changes mid low phase, sampled mid high phase
  task automatic bit_io(input logic b, output logic r);
    #800 sda_low = ~b;
    #800 scl = 1'b1;
    #600 r = sda;
    #600 scl = 1'b0;
  endtask
  // Eight bits first bit most significant, then the acknowledge slot
  task automatic xfer(input logic [7:0] tx, input logic tx_ack,
      output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], rx[i]);
    end
    bit_io(tx_ack, ack);
  endtask
endmodule

// ---- eew_pkg.sv ----
// Package for the two-wire EEPROM target front end
package eew_pkg;
  // ----------------------------------------
  // Device type code, word size and memory address byte count
  // ----------------------------------------
  localparam logic [3:0] EEW_TYPE_CODE = 4'hA;
  localparam int EEW_WORD_BITS = 8;
  localparam int EEW_ADDR_BYTES = 2;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int EEW_CLK_HZ = 20000000;
  localparam int EEW_WRITE_MS = 5;
  localparam int EEW_WRITE_CYCLES = EEW_CLK_HZ / 1000 * EEW_WRITE_MS;
  localparam int EEW_GLITCH_NS = 50;
  localparam int EEW_CLK_NS = 50;
  localparam int EEW_GLITCH_CYCLES_RAW = (EEW_GLITCH_NS + EEW_CLK_NS - 1) / EEW_CLK_NS;
  localparam int EEW_GLITCH_CYCLES = (EEW_GLITCH_CYCLES_RAW < 1) ? 1 : EEW_GLITCH_CYCLES_RAW;
  localparam int EEW_SCL_MAX_KHZ = 400;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [3:0] EEW_BIT_RESET = 4'h0;
  localparam logic [7:0] EEW_SHIFT_RESET = 8'h00;
endpackage

// ---- eew_target.sv ----
// Two-wire serial target front end of an EEPROM
// Functional notes
// - Sample on clock rise, change after fall
// - Internal write cycle lasts at most 5 ms
// - Data changes only while clock low
// - Data line driven open-drain, low only
// - Select only when code matches straps
// - Unconnected straps read as low
// - Protected: ack addresses, nack data, no write
// - Protect pin high guards whole array
// - Reads ignore the protect pin
// - Unconnected protect pin reads low
// - Start: data falls with clock high
// - Stop: data rises with clock high
// - Stop after write data starts write cycle
// - Eight-bit words, ack on ninth clock
// - Ack every written word unless blocked
// - Read: ack address, next byte on ack
// - Nack then stop ends a read
// - No ack: release line, no more data
// - Address word 1010, A2 A1 A0, direction
// - Eighth bit: zero write, one read
// - Mismatch returns to standby without ack
// - Two memory address bytes, each acked
// - Busy writing: no ack to write address
// - Filter glitches under 50 ns
`timescale 1ns/100ps
module eew_target
  import eew_pkg::*;
#(
  parameter int WRITE_CYCLES = EEW_WRITE_CYCLES
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [2:0] chip_select_straps,
  input wire logic write_protect_pin,
  input wire logic [7:0] read_data,
  output logic read_req,
  output logic [7:0] wr_byte,
  output logic wr_byte_valid,
  output logic [7:0] mem_addr_byte,
  output logic mem_addr_valid,
  output logic write_start,
  output logic write_busy
);
  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic rst_s1;
  logic rst_n;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end
  end
  // ----------------------------------------
  // Input synchronisers and glitch filters
  // ----------------------------------------
  logic [1:0] s1;
  logic [1:0] s2;
  logic [1:0] filt;
  logic [1:0] filt_d;
  logic [1:0] next_filt;
  logic [1:0] cnt [2];
  logic [1:0] next_cnt [2];
  logic [2:0] straps_s1;
  logic [2:0] straps_q;
  logic wp_s1;
  logic wp_q;
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      next_cnt[i] = cnt[i];
      next_filt[i] = filt[i];
      if (s2[i] == filt[i]) begin
        next_cnt[i] = 2'h0;
      end else if (int'(cnt[i]) >= EEW_GLITCH_CYCLES) begin
        next_filt[i] = s2[i];
        next_cnt[i] = 2'h0;
      end else begin
        next_cnt[i] = cnt[i] + 2'h1;
      end
    end
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= 2'h3;
      s2 <= 2'h3;
      filt <= 2'h3;
      filt_d <= 2'h3;
      cnt[0] <= 2'h0;
      cnt[1] <= 2'h0;
      straps_s1 <= 3'h0;
      straps_q <= 3'h0;
      wp_s1 <= 1'b0;
      wp_q <= 1'b0;
    end else if (clk_en) begin
      s1 <= {sda_in, scl_in};
      s2 <= s1;
      filt <= next_filt;
      filt_d <= filt;
      cnt[0] <= next_cnt[0];
      cnt[1] <= next_cnt[1];
      straps_s1 <= chip_select_straps;
      straps_q <= straps_s1;
      wp_s1 <= write_protect_pin;
      wp_q <= wp_s1;
    end
  end
  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  assign scl = filt[0];
  assign sda = filt[1];
  assign scl_rise = scl && !filt_d[0];
  assign scl_fall = !scl && filt_d[0];
  assign start_det = scl && filt_d[0] && !sda && filt_d[1];
  assign stop_det = scl && filt_d[0] && sda && !filt_d[1];
  // ----------------------------------------
  // Protocol state machine
  // ----------------------------------------
  typedef enum logic [2:0] {EEW_IDLE, EEW_DEV, EEW_ADDR, EEW_WDATA, EEW_RDATA, EEW_WAIT}
    eew_state_t;
  eew_state_t state;
  eew_state_t next_state;
  logic [3:0] bitn;
  logic [3:0] next_bitn;
  logic [7:0] shift;
  logic [7:0] next_shift;
  logic ack_phase;
  logic next_ack_phase;
  logic drive_low;
  logic next_drive_low;
  logic addr_cnt;
  logic next_addr_cnt;
  logic pend_write;
  logic next_pend_write;
  logic [7:0] next_wr_byte;
  logic next_wr_valid;
  logic [7:0] next_ma_byte;
  logic next_ma_valid;
  logic next_read_req;
  logic next_write_start;
  logic dev_match;
  assign dev_match = (shift[7:4] == EEW_TYPE_CODE) && (shift[3:1] == straps_q);
  always_comb begin
    next_state = state;
    next_bitn = bitn;
    next_shift = shift;
    next_ack_phase = ack_phase;
    next_drive_low = drive_low;
    next_addr_cnt = addr_cnt;
    next_pend_write = pend_write;
    next_wr_byte = wr_byte;
    next_wr_valid = 1'b0;
    next_ma_byte = mem_addr_byte;
    next_ma_valid = 1'b0;
    next_read_req = 1'b0;
    next_write_start = 1'b0;
    if (start_det) begin
      next_state = EEW_DEV;
      next_bitn = EEW_BIT_RESET;
      next_ack_phase = 1'b0;
      next_drive_low = 1'b0;
      next_addr_cnt = 1'b0;
      next_pend_write = 1'b0;
    end else if (stop_det) begin
      next_state = EEW_IDLE;
      next_drive_low = 1'b0;
      next_write_start = pend_write && !write_busy;
      next_pend_write = 1'b0;
    end else if (state != EEW_IDLE && scl_rise && !ack_phase) begin
      if (state == EEW_RDATA) begin
        next_bitn = bitn + 4'h1;
      end else begin
        next_shift = {shift[6:0], sda};
        next_bitn = bitn + 4'h1;
      end
    end else if (state != EEW_IDLE && scl_rise && ack_phase && state == EEW_RDATA) begin
      if (!sda) begin
        next_read_req = 1'b1;
      end else begin
        next_state = EEW_WAIT;
      end
    end else if (state != EEW_IDLE && scl_fall) begin
      if (ack_phase) begin
        next_ack_phase = 1'b0;
        next_bitn = EEW_BIT_RESET;
        next_drive_low = 1'b0;
        if (state == EEW_RDATA) begin
          next_drive_low = !read_data[7];
          next_shift = read_data;
        end
      end else if (bitn == 4'(EEW_WORD_BITS)) begin
        next_ack_phase = 1'b1;
        case (state)
          EEW_DEV: begin
            if (!dev_match || (write_busy && !shift[0])) begin
              next_state = EEW_IDLE;
            end else if (shift[0]) begin
              next_state = EEW_RDATA;
              next_drive_low = 1'b1;
              next_read_req = 1'b1;
            end else begin
              next_state = EEW_ADDR;
              next_addr_cnt = 1'b0;
              next_drive_low = 1'b1;
            end
          end
          EEW_ADDR: begin
            next_drive_low = 1'b1;
            next_ma_byte = shift;
            next_ma_valid = 1'b1;
            if (addr_cnt) begin
              next_state = EEW_WDATA;
            end
            next_addr_cnt = 1'b1;
          end
          EEW_WDATA: begin
            if (wp_q) begin
              next_drive_low = 1'b0;
              next_state = EEW_WAIT;
            end else begin
              next_drive_low = 1'b1;
              next_wr_byte = shift;
              next_wr_valid = 1'b1;
              next_pend_write = 1'b1;
            end
          end
          EEW_RDATA: begin
            next_drive_low = 1'b0;
          end
          default: begin
            next_drive_low = 1'b0;
          end
        endcase
      end else if (state == EEW_RDATA) begin
        next_drive_low = !shift[6];
        next_shift = {shift[6:0], 1'b1};
      end
    end
    if (next_state == EEW_IDLE || next_state == EEW_WAIT) begin
      if (!(state == EEW_WDATA && wp_q && next_ack_phase)) begin
        next_drive_low = next_drive_low && (next_state != EEW_IDLE);
      end
    end
  end
  // ----------------------------------------
  // Write cycle timer
  // ----------------------------------------
  logic [$clog2(WRITE_CYCLES+1)-1:0] wc_cnt;
  logic [$clog2(WRITE_CYCLES+1)-1:0] next_wc_cnt;
  always_comb begin
    next_wc_cnt = wc_cnt;
    if (write_start) begin
      next_wc_cnt = ($clog2(WRITE_CYCLES+1))'(WRITE_CYCLES);
    end else if (wc_cnt != '0) begin
      next_wc_cnt = wc_cnt - 1'b1;
    end
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= EEW_IDLE;
      bitn <= EEW_BIT_RESET;
      shift <= EEW_SHIFT_RESET;
      ack_phase <= 1'b0;
      drive_low <= 1'b0;
      addr_cnt <= 1'b0;
      pend_write <= 1'b0;
      wr_byte <= EEW_SHIFT_RESET;
      wr_byte_valid <= 1'b0;
      mem_addr_byte <= EEW_SHIFT_RESET;
      mem_addr_valid <= 1'b0;
      read_req <= 1'b0;
      write_start <= 1'b0;
      wc_cnt <= '0;
    end else if (clk_en) begin
      state <= next_state;
      bitn <= next_bitn;
      shift <= next_shift;
      ack_phase <= next_ack_phase;
      drive_low <= next_drive_low;
      addr_cnt <= next_addr_cnt;
      pend_write <= next_pend_write;
      wr_byte <= next_wr_byte;
      wr_byte_valid <= next_wr_valid;
      mem_addr_byte <= next_ma_byte;
      mem_addr_valid <= next_ma_valid;
      read_req <= next_read_req;
      write_start <= next_write_start;
      wc_cnt <= next_wc_cnt;
    end
  end
  assign write_busy = (wc_cnt != '0);
  assign sda_out = 1'b0;
  assign sda_oe = drive_low;
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  drive_on_fall_a: assert property (clk_en && $rose(sda_oe) |-> $past(scl_fall))
    else $error("sda drive began off a clock fall");
  protect_nack_a: assert property (state == EEW_WDATA && wp_q |-> !wr_byte_valid)
    else $error("write byte issued while protected");
  stop_write_a: assert property (clk_en && stop_det && pend_write && !write_busy
    |=> write_start ##1 write_busy)
    else $error("stop did not launch write cycle");
  busy_len_a: assert property ($rose(write_busy) && clk_en |-> wc_cnt ==
    ($clog2(WRITE_CYCLES+1))'(WRITE_CYCLES))
    else $error("write cycle length wrong");
  mismatch_idle_a: assert property (clk_en && state == EEW_DEV && scl_fall && !ack_phase
    && bitn == 4'h8 && !dev_match && !start_det && !stop_det |=> state == EEW_IDLE && !sda_oe)
    else $error("mismatched address not ignored");
  start_restart_a: assert property (clk_en && start_det
    |=> state == EEW_DEV && bitn == 4'h0)
    else $error("start did not restart");
  busy_nack_a: assert property (clk_en && write_busy && state == EEW_DEV && scl_fall
    && bitn == 4'h8 && !shift[0] && !start_det && !stop_det |=> !sda_oe)
    else $error("acked write address while busy");
  idle_release_a: assert property (state == EEW_IDLE |-> !sda_oe)
    else $error("idle device drives data line");
  cov_write_c: cover property (write_start);
  cov_read_c: cover property (read_req && state == EEW_RDATA);
  cov_protect_c: cover property (state == EEW_WAIT && wp_q);
endmodule

// ---- testbench.sv ----
// Self-checking bench for the two-wire target front end
`timescale 1ns/100ps
module testbench;
  import eew_pkg::*;
  localparam int WCYC = 2000;
  typedef struct packed {logic [2:0] st; logic wp; logic [7:0] dev; logic ack;} eew_row_t;
  localparam eew_row_t ROWS [8] = '{{3'h5, 1'h0, 8'hAA, 1'h0}, {3'h5, 1'h1, 8'hAB, 1'h0},
    {3'h0, 1'h0, 8'hA0, 1'h0}, {3'h7, 1'h0, 8'hAE, 1'h0}, {3'h5, 1'h0, 8'hBA, 1'h1},
    {3'h5, 1'h0, 8'hA8, 1'h1}, {3'h5, 1'h0, 8'hA2, 1'h1}, {3'h3, 1'h0, 8'hAF, 1'h1}};
  logic sys_clk = 1'b0, reset_n = 1'b0, wp = 1'b0, oe_q = 1'b0;
  logic scl, host_low, sda_oe, sda_out, read_req, wr_v, ma_v, ws, busy, ack;
  logic [2:0] straps = 3'h0;
  logic [7:0] rd_data = 8'h5C, wr_byte, ma_byte, rx, last_wr;
  logic [15:0] ma_seq;
  int bad_count = 0, n_compared = 0, cyc = 0, n_wr = 0, n_ws = 0, blen = 0;
  wire logic sda = ~(host_low | sda_oe);
  eew_host host (.scl(scl), .sda_low(host_low), .sda(sda));
  eew_target #(.WRITE_CYCLES(WCYC)) uut (.sys_clk(sys_clk), .reset_n(reset_n),
    .clk_en(1'b1), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .chip_select_straps(straps), .write_protect_pin(wp), .read_data(rd_data),
    .read_req(read_req), .wr_byte(wr_byte), .wr_byte_valid(wr_v),
    .mem_addr_byte(ma_byte), .mem_addr_valid(ma_v), .write_start(ws),
    .write_busy(busy));
  // ----
  // Helpers
  // ----
  task automatic test_done();
    if (bad_count == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic dev(input logic [7:0] d, input logic exp);
    host.start();
    host.xfer(d, 1'b1, rx, ack);
    check("dev_ack", exp, ack);
    if (!ack && d[0]) begin
      host.xfer(8'hFF, 1'b1, rx, ack);
      check("read_byte", rd_data, rx);
    end
    host.stop();
  endtask
  task automatic wr(input logic [7:0] d, input logic exp);
    logic [7:0] b [4];
    b = '{8'hAA, 8'h01, 8'h2F, d};
    host.start();
    for (int i = 0; i < 4; i++) begin
      host.xfer(b[i], 1'b1, rx, ack);
      check("write_ack", (i == 3) ? exp : 1'b0, ack);
    end
    host.stop();
  endtask
  // ----
  // Memory side model and monitors
  // ----
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (read_req) rd_data <= rd_data + 8'h11;
    if (wr_v) n_wr <= n_wr + 1;
    if (wr_v) last_wr <= wr_byte;
    if (ma_v) ma_seq <= {ma_seq[7:0], ma_byte};
    if (ws) n_ws <= n_ws + 1;
    if (busy) blen <= blen + 1;
    if (reset_n && scl && sda_oe !== oe_q) begin
      bad_count++;
      $display("unexpected sda_oe_change: expected %h seen %h", oe_q, sda_oe);
    end
    oe_q <= sda_oe;
    if (cyc == 40000) begin
      bad_count++;
      test_done();
    end
  end
  initial begin
    forever #25 sys_clk = ~sys_clk;
  end
  // ----
  // Main sequence
  // ----
  initial begin
    logic [7:0] e;
    repeat (3) @(posedge sys_clk);
    #2 reset_n = 1'b1;
    repeat (10) @(posedge sys_clk);
    #2 check("sda_out", 16'h0, sda_out);
    for (int i = 0; i < 8; i++) begin
      straps = ROWS[i].st;
      wp = ROWS[i].wp;
      dev(ROWS[i].dev, ROWS[i].ack);
    end
    straps = 3'h5;
    wp = 1'b0;
    wr(8'h96, 1'b0);
    check("addr_pair", 16'h012F, ma_seq);
    check("wr_byte", 16'h0096, last_wr);
    check("write_start", 16'h1, n_ws[15:0]);
    check("busy", 16'h1, busy);
    dev(8'hAA, 1'b1);
    dev(8'hAB, 1'b0);
    for (int k = 0; k < WCYC + 100 && busy; k++) @(posedge sys_clk);
    #2 check("busy_len", 16'h1, blen >= WCYC - 1 && blen <= WCYC);
    dev(8'hAA, 1'b0);
    wp = 1'b1;
    wr(8'h55, 1'b1);
    check("wr_count", 16'h1, n_wr[15:0]);
    check("write_start", 16'h1, n_ws[15:0]);
    wp = 1'b0;
    host.start();
    host.glitch();
    host.xfer(8'hAB, 1'b1, rx, ack);
    check("seq_ack", 16'h0, ack);
    e = rd_data;
    host.xfer(8'hFF, 1'b0, rx, ack);
    check("seq0", e, rx);
    host.xfer(8'hFF, 1'b1, rx, ack);
    check("seq1", 8'(e + 8'h11), rx);
    host.xfer(8'hFF, 1'b1, rx, ack);
    check("idle_line", 16'h00FF, rx);
    host.stop();
    host.start();
    host.bit_io(1'b1, ack);
    host.bit_io(1'b0, ack);
    dev(8'hAB, 1'b0);
    test_done();
  end
endmodule
